// [include/fdc_pos_defs.svh]
// offsets, command codes, interrupt codes, reset values and timing constants of the positioning block
`ifndef FDC_POS_DEFS_SVH
`define FDC_POS_DEFS_SVH
`define REG_CMD 8'h00
`define REG_SPEC 8'h04
`define REG_STAT 8'h08
`define REG_RES 8'h0c
`define REG_PCN 8'h10
`define REG_CTRL 8'h14
`define OP_RECAL 3'h1
`define OP_SEEK 3'h2
`define OP_SENSE_INT 3'h3
`define OP_SENSE_DRV 3'h4
`define SPEC_RST 19'h0_0000
`define RECAL_MAX_STEPS 7'd79
`define IC_NORMAL 2'b00
`define IC_ABNORMAL 2'b01
`define IC_INVALID 2'b10
`define IC_POLL 2'b11
`define CLK_NS 50
`define UNIT_2M_NS 125000
`define UNIT_1M_NS 250000
`define UNIT_500K_NS 500000
`define UNIT_300K_NS 833333
`define UNIT_250K_NS 1000000
`endif

// [include/fdc_pos_pkg.sv]
// types of the positioning block
package fdc_pos_pkg;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_CHK = 2'b01,
    D_STEP = 2'b11,
    D_WAIT = 2'b10
  } drv_state_t;
  typedef enum logic [1:0] {
    H_OFF = 2'b00,
    H_LOAD = 2'b01,
    H_ON = 2'b11,
    H_HOLD = 2'b10
  } head_state_t;
  typedef struct packed {
    drv_state_t st;
    logic recal;
    logic dir;
    logic [7:0] present_cylinder;
    logic [7:0] target_cylinder;
    logic [6:0] steps;
    logic [4:0] gap;
  } drive_t;
  typedef struct packed {
    logic [1:0] interrupt_code;
    logic seek_end_flag;
    logic equipment_check_flag;
    logic not_ready;
    logic head;
    logic [1:0] drive;
  } st0_t;
endpackage

// [logic/floppy_head_positioning_ctrl.sv]
// head positioning, interrupt status and specify timing of the disk controller
`timescale 1ns/1ps
`include "fdc_pos_defs.svh"
module floppy_head_positioning_ctrl #(
  parameter int unsigned NDRV = 4,
  parameter int unsigned UNIT_CYC_2M = `UNIT_2M_NS / `CLK_NS,
  parameter int unsigned UNIT_CYC_1M = `UNIT_1M_NS / `CLK_NS,
  parameter int unsigned UNIT_CYC_500K = `UNIT_500K_NS / `CLK_NS,
  parameter int unsigned UNIT_CYC_300K = `UNIT_300K_NS / `CLK_NS,
  parameter int unsigned UNIT_CYC_250K = `UNIT_250K_NS / `CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NDRV-1:0] track_zero_in,
  output logic [NDRV-1:0] step_o,
  output logic [NDRV-1:0] dir_o,
  output logic head_load_o,
  input wire logic rw_start_i,
  output logic rw_go_o,
  input wire logic rw_exec_end_i,
  input wire logic rw_result_i,
  input wire logic byte_needed_i,
  input wire logic byte_done_i,
  output logic dma_req_o,
  input wire logic dma_ack_i,
  output logic intr_o,
  output fdc_pos_pkg::st0_t st0_o
);
  import fdc_pos_pkg::*;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic bvalid_q, rvalid_q, wr_en, rd_en, wr_ok;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_val;
  logic [18:0] spec_q;
  logic low_power_q, lp_exit, cmd_wr, cmd_busy_q;
  logic [2:0] cmd_op;
  logic [1:0] cmd_drv;

  assign wr_en = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_en;
  assign s_axi_wready = wr_en;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign rd_en = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rd_en;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_ok = s_axi_awaddr == `REG_CMD || s_axi_awaddr == `REG_SPEC ||
                 s_axi_awaddr == `REG_CTRL;
  assign cmd_wr = wr_en && s_axi_awaddr == `REG_CMD && !low_power_q;
  assign cmd_op = s_axi_wdata[2:0];
  assign cmd_drv = s_axi_wdata[5:4];
  assign lp_exit = wr_en && s_axi_awaddr == `REG_CTRL && s_axi_wstrb[0] &&
                   low_power_q && !s_axi_wdata[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spec_q <= `SPEC_RST;
      low_power_q <= 1'b0;
    end else if (wr_en) begin
      if (s_axi_awaddr == `REG_SPEC) begin
        for (int b = 0; b < 3; b++) begin
          if (s_axi_wstrb[b]) begin
            for (int k = 0; k < 8; k++) begin
              if (b * 8 + k < 19) begin
                spec_q[b*8+k] <= s_axi_wdata[b*8+k];
              end
            end
          end
        end
      end
      if (s_axi_awaddr == `REG_CTRL && s_axi_wstrb[0]) begin
        low_power_q <= s_axi_wdata[0];
      end
    end
  end

  // command busy is registered: high for the one cycle after the accepting cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_busy_q <= 1'b0;
    end else begin
      cmd_busy_q <= cmd_wr;
    end
  end

  // ----------------------------------------
  // timing unit per data rate
  // ----------------------------------------
  logic [3:0] step_rate_time;
  logic [3:0] head_unload_time;
  logic [6:0] head_load_time;
  logic dma_disable_bit;
  logic [14:0] unit_cnt_q, unit_lim;
  logic unit_tick;

  assign step_rate_time = spec_q[3:0];
  assign head_unload_time = spec_q[7:4];
  assign head_load_time = spec_q[14:8];
  assign dma_disable_bit = spec_q[15];

  always_comb begin
    unique case (spec_q[18:16])
      3'h1: unit_lim = 15'(UNIT_CYC_300K - 1);
      3'h2: unit_lim = 15'(UNIT_CYC_250K - 1);
      3'h3: unit_lim = 15'(UNIT_CYC_1M - 1);
      3'h4: unit_lim = 15'(UNIT_CYC_2M - 1);
      default: unit_lim = 15'(UNIT_CYC_500K - 1);
    endcase
  end

  assign unit_tick = unit_cnt_q >= unit_lim;

  always_ff @(posedge aclk) begin
    if (!aresetn || unit_tick) begin
      unit_cnt_q <= 15'h0000;
    end else begin
      unit_cnt_q <= unit_cnt_q + 15'h0001;
    end
  end

  // ----------------------------------------
  // per-drive step sequencers
  // ----------------------------------------
  logic [NDRV-1:0] trk_m_q, trk_s_q;
  drive_t drv_q [NDRV];
  logic [NDRV-1:0] done_q, done_ec_q, pend_q, pend_ec_q, sense_clr;
  logic [4:0] srt_gap;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trk_m_q <= '0;
      trk_s_q <= '0;
    end else begin
      trk_m_q <= track_zero_in;
      trk_s_q <= trk_m_q;
    end
  end

  // two units per step-rate count; first gap may come out one tick short
  assign srt_gap = 5'(({1'b0, ~step_rate_time} << 1) + 5'd1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NDRV; i++) begin
        drv_q[i] <= '0;
      end
      done_q <= '0;
      done_ec_q <= '0;
    end else begin
      done_q <= '0;
      done_ec_q <= '0;
      for (int i = 0; i < NDRV; i++) begin
        unique case (drv_q[i].st)
          D_IDLE: ;
          D_CHK: begin
            if (drv_q[i].recal) begin
              if (trk_s_q[i]) begin
                drv_q[i].st <= D_IDLE;
                done_q[i] <= 1'b1;
              end else if (drv_q[i].steps == `RECAL_MAX_STEPS) begin
                drv_q[i].st <= D_IDLE;
                done_q[i] <= 1'b1;
                done_ec_q[i] <= 1'b1;
              end else begin
                drv_q[i].st <= D_STEP;
                drv_q[i].dir <= 1'b0;
                drv_q[i].steps <= drv_q[i].steps + 7'd1;
              end
            end else if (drv_q[i].present_cylinder == drv_q[i].target_cylinder) begin
              drv_q[i].st <= D_IDLE;
              done_q[i] <= 1'b1;
            end else begin
              drv_q[i].st <= D_STEP;
              if (drv_q[i].present_cylinder < drv_q[i].target_cylinder) begin
                drv_q[i].dir <= 1'b1;
                drv_q[i].present_cylinder <= drv_q[i].present_cylinder + 8'd1;
              end else begin
                drv_q[i].dir <= 1'b0;
                drv_q[i].present_cylinder <= drv_q[i].present_cylinder - 8'd1;
              end
            end
          end
          D_STEP: begin
            if (unit_tick) begin
              drv_q[i].st <= D_WAIT;
              drv_q[i].gap <= srt_gap;
            end
          end
          D_WAIT: begin
            if (unit_tick) begin
              if (drv_q[i].gap == 5'd0) begin
                drv_q[i].st <= D_CHK;
              end else begin
                drv_q[i].gap <= drv_q[i].gap - 5'd1;
              end
            end
          end
        endcase
        // other drives keep stepping while a new command is taken
        if (cmd_wr && cmd_drv == 2'(i) &&
            (cmd_op == `OP_RECAL || cmd_op == `OP_SEEK)) begin
          drv_q[i].st <= D_CHK;
          drv_q[i].recal <= cmd_op == `OP_RECAL;
          drv_q[i].steps <= 7'd0;
          drv_q[i].target_cylinder <= s_axi_wdata[15:8];
          if (cmd_op == `OP_RECAL) begin
            drv_q[i].present_cylinder <= 8'h00;
          end
        end
        if (lp_exit) begin
          drv_q[i].present_cylinder <= 8'h00;
        end
      end
    end
  end

  for (genvar g = 0; g < NDRV; g++) begin : g_pins
    assign step_o[g] = drv_q[g].st == D_STEP;
    assign dir_o[g] = drv_q[g].dir;
  end

  // ----------------------------------------
  // interrupt sources and sense
  // ----------------------------------------
  logic poll_q, rw_pend_q, rqm_q, rqm_int_q, dma_req_q, sense_int;
  logic found;
  logic [1:0] sel;

  assign sense_int = cmd_wr && cmd_op == `OP_SENSE_INT;

  always_comb begin
    found = 1'b0;
    sel = 2'd0;
    sense_clr = '0;
    for (int i = NDRV - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        found = 1'b1;
        sel = 2'(i);
      end
    end
    if (sense_int && found) begin
      sense_clr[sel] = 1'b1;
    end
  end

  // set after clear, so an end in the sensing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn || lp_exit) begin
      pend_q <= '0;
      pend_ec_q <= '0;
    end else begin
      for (int i = 0; i < NDRV; i++) begin
        if (sense_clr[i]) begin
          pend_q[i] <= 1'b0;
        end
        if (done_q[i]) begin
          pend_q[i] <= 1'b1;
          pend_ec_q[i] <= done_ec_q[i];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      poll_q <= 1'b1;
      rw_pend_q <= 1'b0;
    end else begin
      if (sense_int && !found) begin
        poll_q <= 1'b0;
        rw_pend_q <= poll_q && rw_pend_q;
      end
      if (rw_result_i) begin
        rw_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rqm_q <= 1'b0;
      rqm_int_q <= 1'b0;
      dma_req_q <= 1'b0;
    end else begin
      if (byte_done_i) begin
        rqm_q <= 1'b0;
        rqm_int_q <= 1'b0;
      end
      // a sense with no drive pending drops the byte interrupt unless polling, the request bit stays
      if (sense_int && !found) begin
        rqm_int_q <= poll_q && rqm_int_q;
      end
      if (dma_ack_i) begin
        dma_req_q <= 1'b0;
      end
      if (byte_needed_i) begin
        rqm_q <= dma_disable_bit;
        rqm_int_q <= dma_disable_bit;
        dma_req_q <= !dma_disable_bit;
      end
    end
  end

  assign dma_req_o = dma_req_q;
  assign intr_o = |pend_q || poll_q || rw_pend_q || rqm_int_q;

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  st0_t st0_q;
  logic [7:0] pcn_rpt_q, st3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || lp_exit) begin
      st0_q <= '0;
      pcn_rpt_q <= 8'h00;
      st3_q <= 8'h00;
    end else if (sense_int) begin
      st0_q.head <= 1'b0;
      st0_q.not_ready <= 1'b0;
      st0_q.drive <= sel;
      st0_q.equipment_check_flag <= found && pend_ec_q[sel];
      st0_q.seek_end_flag <= found;
      pcn_rpt_q <= drv_q[sel].present_cylinder;
      if (found) begin
        st0_q.interrupt_code <= pend_ec_q[sel] ? `IC_ABNORMAL : `IC_NORMAL;
      end else if (poll_q) begin
        st0_q.interrupt_code <= `IC_POLL;
      end else if (rw_pend_q || rqm_q) begin
        st0_q.interrupt_code <= `IC_NORMAL;
      end else begin
        st0_q.interrupt_code <= `IC_INVALID;
      end
    end else if (cmd_wr && cmd_op == `OP_SENSE_DRV) begin
      st3_q <= {3'b000, trk_s_q[cmd_drv], 2'b00, cmd_drv};
    end
  end

  assign st0_o = st0_q;

  // ----------------------------------------
  // head load and unload timing
  // ----------------------------------------
  head_state_t hd_q;
  logic [9:0] hd_cnt_q;
  logic rw_go_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hd_q <= H_OFF;
      hd_cnt_q <= 10'd0;
      rw_go_q <= 1'b0;
    end else begin
      rw_go_q <= 1'b0;
      unique case (hd_q)
        H_OFF: begin
          if (rw_start_i) begin
            hd_q <= H_LOAD;
            hd_cnt_q <= (head_load_time == 7'd0) ? 10'd512 : {1'b0, head_load_time, 2'b00};
          end
        end
        H_LOAD: begin
          if (unit_tick) begin
            if (hd_cnt_q == 10'd0) begin
              hd_q <= H_ON;
              rw_go_q <= 1'b1;
            end else begin
              hd_cnt_q <= hd_cnt_q - 10'd1;
            end
          end
        end
        H_ON: begin
          if (rw_exec_end_i) begin
            hd_q <= H_HOLD;
            hd_cnt_q <= (head_unload_time == 4'd0) ? 10'd512 : {1'b0, head_unload_time, 5'b00000};
          end else if (rw_start_i) begin
            rw_go_q <= 1'b1;
          end
        end
        H_HOLD: begin
          if (rw_start_i) begin
            hd_q <= H_ON;
            rw_go_q <= 1'b1;
          end else if (unit_tick) begin
            if (hd_cnt_q == 10'd0) begin
              hd_q <= H_OFF;
            end else begin
              hd_cnt_q <= hd_cnt_q - 10'd1;
            end
          end
        end
      endcase
    end
  end

  assign head_load_o = hd_q != H_OFF;
  assign rw_go_o = rw_go_q;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [NDRV-1:0] drv_busy;

  always_comb begin
    for (int i = 0; i < NDRV; i++) begin
      drv_busy[i] = drv_q[i].st != D_IDLE || pend_q[i];
    end
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `REG_SPEC: rd_val = {13'h0000, spec_q};
      `REG_STAT: rd_val = {22'h00_0000, head_load_o, dma_req_q, rqm_q, intr_o,
                           cmd_busy_q, 1'b0, 4'(drv_busy)};
      `REG_RES: rd_val = {8'h00, st3_q, pcn_rpt_q, st0_q};
      `REG_PCN: begin
        for (int i = 0; i < NDRV; i++) begin
          rd_val[i*8 +: 8] = drv_q[i].present_cylinder;
        end
      end
      `REG_CTRL: rd_val = {31'h0000_0000, low_power_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else if (rd_en) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= (s_axi_araddr == `REG_CMD || s_axi_araddr[7:5] != 3'h0 ||
                  s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > `REG_CTRL) ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence recal_cmd0;
    cmd_wr && cmd_drv == 2'd0 && cmd_op == `OP_RECAL;
  endsequence
  sequence chk_to_step0;
    drv_q[0].st == D_CHK ##1 drv_q[0].st == D_STEP;
  endsequence

  AST_RECAL_ZERO: assert property (recal_cmd0 |=> drv_q[0].present_cylinder == 8'h00)
    else $error("recalibrate did not zero cylinder");
  AST_RECAL_DIR: assert property ((drv_q[0].recal and chk_to_step0) |-> !dir_o[0])
    else $error("recalibrate stepped inward");
  AST_RECAL_EC: assert property (drv_q[0].st == D_CHK && drv_q[0].recal && !trk_s_q[0] &&
      drv_q[0].steps == 7'd79 |=> done_ec_q[0] ##1 pend_q[0])
    else $error("recalibrate limit not flagged");
  AST_SEEK_IN: assert property (drv_q[0].st == D_CHK && !drv_q[0].recal &&
      drv_q[0].present_cylinder < drv_q[0].target_cylinder && !cmd_wr
      |=> dir_o[0] && step_o[0])
    else $error("seek inward direction wrong");
  AST_SEEK_END: assert property (drv_q[0].st == D_CHK && !drv_q[0].recal &&
      drv_q[0].present_cylinder == drv_q[0].target_cylinder && !cmd_wr
      |=> drv_q[0].st == D_IDLE ##1 pend_q[0] && intr_o)
    else $error("seek end not raised");
  AST_HEAD_ZERO: assert property (st0_q.head == 1'b0)
    else $error("head bit set in status zero");
  AST_LP_EXIT: assert property (lp_exit |=> pend_q == '0 && drv_q[0].present_cylinder == 8'h00)
    else $error("low power exit left state");
  AST_SENSE_CLR: assert property (sense_int && found && !done_q[sel] |=> !pend_q[$past(sel)])
    else $error("sense did not clear pending drive");
  AST_DMA_MODE: assert property (byte_needed_i |=> (dma_disable_bit ? rqm_q && intr_o
      : dma_req_o))
    else $error("transfer request on wrong path");
  AST_HEAD_GO: assert property (rw_go_o |-> head_load_o)
    else $error("transfer started with head unloaded");
endmodule

// [tb/fdd_model.sv]
// drive model: head stepping and track-zero sensor per drive
`timescale 1ns/1ps
module fdd_model #(
  parameter int NDRV = 4,
  parameter int START3 = 100,
  parameter int LAG_NS = 0
) (
  input wire logic aclk,
  input wire logic [NDRV-1:0] step_o,
  input wire logic [NDRV-1:0] dir_o,
  output logic [NDRV-1:0] track_zero_in
);
  int pos[NDRV];
  logic [NDRV-1:0] step_prev;
  logic [NDRV-1:0] at_zero;
  initial begin
    step_prev = '0;
    for (int i = 0; i < NDRV; i++) begin
      pos[i] = (i == 3) ? START3 : 0;
      at_zero[i] = (pos[i] == 0);
    end
  end
  // ----------------------------------------
  // head moves one track per rising step edge
  // ----------------------------------------
  always @(posedge aclk) begin
    for (int i = 0; i < NDRV; i++) begin
      if (step_o[i] && !step_prev[i]) begin
        if (dir_o[i]) pos[i] = pos[i] + 1;
        else if (pos[i] > 0) pos[i] = pos[i] - 1;
      end
      at_zero[i] <= (pos[i] == 0);
    end
    step_prev <= step_o;
  end
  // slow sensor settles after a lag
  assign #(LAG_NS) track_zero_in = at_zero;
endmodule

// [tb/floppy_head_positioning_ctrl_bench.sv]
// self-checking bench of the head positioning block
`timescale 1ns/1ps
`include "fdc_pos_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module floppy_head_positioning_ctrl_bench;
  localparam logic [31:0] SPEC = 32'h0000_011f;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] tz, step, dir;
  logic hl, go, dreq, intr;
  logic [5:0] ev;
  logic [3:0] strb;
  fdc_pos_pkg::st0_t st0;
  int miscompares, check_count;
  wire [6:0] flags = {hl, go, intr, rvalid, arready, bvalid, awready & wready};
  floppy_head_positioning_ctrl #(.UNIT_CYC_2M(2), .UNIT_CYC_1M(4), .UNIT_CYC_500K(4),
    .UNIT_CYC_300K(4), .UNIT_CYC_250K(4)) floppy_head_positioning_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .track_zero_in(tz), .step_o(step), .dir_o(dir), .head_load_o(hl),
    .rw_start_i(ev[0]), .rw_go_o(go), .rw_exec_end_i(ev[1]), .rw_result_i(ev[2]),
    .byte_needed_i(ev[3]), .byte_done_i(ev[4]), .dma_req_o(dreq), .dma_ack_i(ev[5]),
    .intr_o(intr), .st0_o(st0));
  fdd_model #(.LAG_NS(120)) fdd_model_i (.aclk(aclk), .step_o(step), .dir_o(dir),
    .track_zero_in(tz));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hs(input int k, input logic lvl, output int n);
    for (n = 1; n <= 4000; n++) begin
      @(posedge aclk);
      if (flags[k] === lvl) return;
    end
    miscompares++;
    $display("CHECK FAILED t=%0t timeout", $time);
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    hs(0, 1'b1, n);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    hs(1, 1'b1, n);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    hs(2, 1'b1, n);
    arvalid <= 1'b0;
    rready <= 1'b1;
    hs(3, 1'b1, n);
    d = rdata;
    rready <= 1'b0;
    `CHK(rresp, er)
  endtask
  task automatic cmd(input logic [2:0] op, input logic [1:0] d, input logic [7:0] t);
    wr(`REG_CMD, {16'h0000, t, 2'b00, d, 1'b0, op});
  endtask
  task automatic sense(output logic [7:0] s0, output logic [7:0] cy);
    logic [31:0] r;
    cmd(`OP_SENSE_INT, 2'd0, 8'h00);
    rd(`REG_RES, r);
    s0 = r[7:0];
    cy = r[15:8];
  endtask
  task automatic pulse(input int k);
    ev <= 6'h01 << k;
    @(posedge aclk);
    ev <= '0;
    @(posedge aclk);
    @(posedge aclk);
  endtask
  // counts step rises of one drive until the interrupt, gap between rise 2 and 3
  task automatic run(input int d, input logic xd, output int steps, output int gap);
    int t0;
    logic p;
    steps = 0;
    gap = 0;
    t0 = 0;
    p = 1'b0;
    for (int c = 0; c < 4000 && intr !== 1'b1; c++) begin
      @(posedge aclk);
      if (step[d] && !p) begin
        steps++;
        if (steps == 3) gap = c - t0;
        t0 = c;
        `CHK(dir[d], xd)
      end
      p = step[d];
    end
    if (intr !== 1'b1) hs(4, 1'b1, t0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] s0, cy;
    `CHK(intr, 1'b1)
    rd(`REG_SPEC, q);
    `CHK(q, 32'h0)
    rd(8'h20, q, 2'b10);
    rd(`REG_CMD, q, 2'b10);
    wr(8'h20, 32'h0, 2'b10);
    sense(s0, cy);
    `CHK(s0[7:5], {`IC_POLL, 1'b0})
    `CHK(intr, 1'b0)
    strb <= 4'h2;
    wr(`REG_SPEC, 32'hffff_ffff);
    strb <= 4'hf;
    rd(`REG_SPEC, q);
    `CHK(q, 32'h0000_ff00)
    wr(`REG_SPEC, SPEC);
    rd(`REG_SPEC, q);
    `CHK(q, SPEC)
    $display("test reset done");
  endtask
  task automatic t_seek();
    int n, g;
    logic [7:0] s0, cy;
    cmd(`OP_SEEK, 2'd0, 8'd3);
    run(0, 1'b1, n, g);
    `CHK(n, 3)
    `CHK(g inside {[8:14]}, 1'b1)
    rd(`REG_STAT, q);
    `CHK(q[0], 1'b1)
    sense(s0, cy);
    `CHK(s0, {`IC_NORMAL, 4'b1000, 2'd0})
    `CHK(cy, 8'd3)
    `CHK(intr, 1'b0)
    rd(`REG_STAT, q);
    `CHK(q[0], 1'b0)
    cmd(`OP_SEEK, 2'd0, 8'd1);
    run(0, 1'b0, n, g);
    `CHK(n, 2)
    sense(s0, cy);
    `CHK(cy, 8'd1)
    $display("test seek done");
  endtask
  task automatic t_recal();
    int n, g;
    logic [7:0] s0, cy;
    cmd(`OP_RECAL, 2'd0, 8'h00);
    run(0, 1'b0, n, g);
    `CHK(n, 1)
    sense(s0, cy);
    `CHK(s0, {`IC_NORMAL, 4'b1000, 2'd0})
    `CHK(cy, 8'd0)
    cmd(`OP_SENSE_DRV, 2'd0, 8'h00);
    rd(`REG_RES, q);
    `CHK(q[23:16], 8'h10)
    cmd(`OP_RECAL, 2'd3, 8'h00);
    run(3, 1'b0, n, g);
    `CHK(n, 79)
    sense(s0, cy);
    `CHK(s0, {`IC_ABNORMAL, 4'b1100, 2'd3})
    $display("test recal done");
  endtask
  task automatic t_multi();
    int n;
    logic [7:0] s0, cy;
    cmd(`OP_SEEK, 2'd1, 8'd5);
    cmd(`OP_SEEK, 2'd2, 8'd2);
    rd(`REG_STAT, q);
    `CHK(q[5], 1'b0)
    `CHK(q[2:1], 2'b11)
    hs(4, 1'b1, n);
    sense(s0, cy);
    `CHK({s0, cy}, {`IC_NORMAL, 4'b1000, 2'd2, 8'd2})
    hs(4, 1'b1, n);
    sense(s0, cy);
    `CHK({s0, cy}, {`IC_NORMAL, 4'b1000, 2'd1, 8'd5})
    rd(`REG_PCN, q);
    `CHK(q[23:0], 24'h02_05_00)
    $display("test multi done");
  endtask
  task automatic t_xfer();
    logic [7:0] s0, cy;
    pulse(3);
    `CHK(dreq, 1'b1)
    `CHK(intr, 1'b0)
    pulse(5);
    `CHK(dreq, 1'b0)
    wr(`REG_SPEC, SPEC | 32'h0000_8000);
    pulse(3);
    `CHK(intr, 1'b1)
    `CHK(dreq, 1'b0)
    rd(`REG_STAT, q);
    `CHK(q[7], 1'b1)
    sense(s0, cy);
    `CHK(s0[7:5], 3'b000)
    `CHK(intr, 1'b0)
    pulse(4);
    rd(`REG_STAT, q);
    `CHK(q[7], 1'b0)
    pulse(2);
    `CHK(intr, 1'b1)
    sense(s0, cy);
    `CHK(s0[7:5], 3'b000)
    `CHK(intr, 1'b0)
    $display("test transfer done");
  endtask
  task automatic t_head(input logic [2:0] rate, input int u);
    int n;
    wr(`REG_SPEC, {13'h0000, rate, SPEC[15:0]});
    pulse(0);
    hs(5, 1'b1, n);
    `CHK(n inside {[3*u-4:5*u+2]}, 1'b1)
    `CHK(hl, 1'b1)
    pulse(1);
    hs(6, 1'b0, n);
    `CHK(n inside {[31*u-4:33*u+2]}, 1'b1)
    $display("test head done");
  endtask
  task automatic t_lp();
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL, q);
    `CHK(q[0], 1'b1)
    wr(`REG_CTRL, 32'h0);
    rd(`REG_PCN, q);
    `CHK(q, 32'h0)
    `CHK(st0, 8'h00)
    $display("test low power done");
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ev} = '0;
    strb = 4'hf;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_seek();
    t_recal();
    t_multi();
    t_xfer();
    t_head(3'd0, 4);
    t_head(3'd4, 2);
    t_lp();
    summarize();
  end
endmodule
